// ### common/shp_pkg.sv
package shp_pkg;

  // Line-control codes
  localparam logic [7:0] ENQ_CODE        = 8'h05;
  localparam logic [7:0] EOT_CODE        = 8'h04;
  localparam logic [7:0] ACK_CODE        = 8'h06;
  localparam logic [7:0] NAK_CODE        = 8'h15;
  localparam logic [7:0] RECOG_MARK      = 8'h80;

  // Block layout
  localparam logic [7:0] MAX_COUNT       = 8'hf0;
  localparam logic [8:0] BLOCK_OVERHEAD  = 9'h004;
  localparam logic [7:0] ERR_REPLY_COUNT = 8'h01;
  localparam logic [8:0] ERR_REPLY_LEN   = 9'h005;
  localparam logic [7:0] ERR_CODE_COUNT  = 8'ha0;
  localparam logic [3:0] CMD_ID          = 4'h0;
  localparam logic [3:0] CMD_INIT        = 4'h1;
  localparam logic [3:0] CMD_STATUS      = 4'h2;
  localparam logic [3:0] CMD_PARAM       = 4'h7;
  localparam logic [3:0] CMD_ALARM       = 4'h9;
  localparam logic [3:0] MODE_SET_P2P    = 4'h8;
  localparam logic [3:0] MODE_SET_MD     = 4'h9;
  localparam logic [7:0] INIT_COUNT      = 8'h05;
  localparam logic [7:0] MD_MIN_DELAY    = 8'h02;
  localparam logic [3:0] RETRY_MAX       = 4'h8;

  // Timing: one timer step is 1 ms
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          STEP_NS         = 1000000;
  localparam int          STEP_CYCLES     =
    (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] STEPS_PER_TENTH = 16'h0064;

  // Register map (byte addresses)
  localparam logic [11:0] CTRL_OFS        = 12'h000;
  localparam logic [11:0] PRM_OFS         = 12'h004;
  localparam logic [11:0] STAT_OFS        = 12'h008;
  localparam logic [1:0]  REG_REGION      = 2'h0;
  localparam logic [1:0]  RX_REGION       = 2'h1;
  localparam logic [1:0]  TX_REGION       = 2'h2;
  localparam int          CTRL_MD_BIT     = 0;
  localparam int          CTRL_SEND_BIT   = 1;
  localparam int          CTRL_AXIS_LSB   = 8;
  localparam int          ST_RX_OK        = 0;
  localparam int          ST_TX_OK        = 1;
  localparam int          ST_TX_ERR       = 2;
  localparam int          ST_CNT_ERR      = 3;
  localparam int          ST_NAK_SENT     = 4;
  localparam logic [6:0]  AXIS_RESET      = 7'h01;

  typedef struct packed {
    logic       ms;
    logic [3:0] retry_limit;
    logic [7:0] t6;
    logic [7:0] t2;
    logic [7:0] t1;
  } shp_prm_t;

  localparam shp_prm_t P2P_DEFAULT =
    '{ms: 1'b0, retry_limit: 4'h1, t6: 8'h00, t2: 8'h05, t1: 8'h05};
  localparam shp_prm_t MD_DEFAULT =
    '{ms: 1'b0, retry_limit: 4'h1, t6: 8'h06, t2: 8'h01, t1: 8'h01};

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } shp_byte_t;

  typedef enum logic [3:0] {
    S_IDLE, S_ENQ_ID, S_EOT_TX, S_EOT_ID_TX, S_WAIT_FIRST, S_RX_BLK,
    S_REPLY, S_ENQ_TX, S_ENQ_ID_TX, S_WAIT_EOT, S_WAIT_EOT_ID,
    S_TX_BLK, S_WAIT_ACK
  } shp_state_t;

endpackage

// ### hdl/shp_link.sv
`timescale 1ns/1ns

// Function
// RULE1: Sending EOT in answer to ENQ puts the module in reception mode.
// RULE2: Transmission mode starts only after own ENQ answered by EOT.
// RULE3: Slave waiting for EOT that gets ENQ yields and receives.
// RULE4: Whole block sent back to back, then wait for ACK.
// RULE5: Missing ACK, NAK or other code restarts exchange from ENQ.
// RULE6: First byte gives count; that many plus three more form block.
// RULE7: ACK when block sums to zero; NAK on bad sum or gap timeout.
// RULE8: Count byte holds parameter byte count, 0 to 240.
// RULE9: Block carries axis 0..127, command and mode 0..15.
// RULE10: Last byte is two's complement of sum of preceding bytes.
// RULE11: Gap timeout in tenths, default 5 or 1; expiry gives NAK.
// RULE12: ENQ resent when EOT misses the protocol timeout.
// RULE13: No first byte within protocol timeout after EOT: NAK, leave.
// RULE14: Response delay in ms before EOT, ACK or first block byte.
// RULE15: Retry limit 1..8, default 1; exceeding it flags an error.
// RULE16: Master select decides ENQ contention; slave by default.
// RULE17: Host answers no sooner than 2 ms, within protocol timeout.
// RULE18: Intervals are timed from the stop bit of the last character.
// RULE19: Wrong byte count gets an error-code-only reply.
// RULE20: Commands 0, 1, 2, 7, 9 are the recognised command groups.
// RULE21: Initialisation command rewrites timing, retry, master select.
// RULE22: Host sends only listed command and mode codes.
// RULE23: Host takes execution right, writes, commits, releases it.
// RULE24: Host waits 50 ms before addressing another axis.
// RULE25: ENQ 05h, EOT 04h, ACK 06h, NAK 15h.
// RULE26: Multi-drop ENQ/EOT followed by bit7-marked module ID byte.
// RULE27: Checksum is modulo-256 byte arithmetic.
// RULE28: Multi-drop ENQ for another axis address is ignored.
module shp_link #(
  parameter int STEP_CYC = shp_pkg::STEP_CYCLES
) (
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [11:0]       paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  shp_pkg::shp_byte_t rx_byte,
  input  logic              tx_ready,
  input  logic              tx_end,
  output shp_pkg::shp_byte_t tx_byte
);

  shp_pkg::shp_state_t state_q;
  shp_pkg::shp_prm_t   prm_q [2];
  shp_pkg::shp_prm_t   prm;
  shp_pkg::shp_byte_t  tx_q;
  logic [7:0]          rx_mem [256];
  logic [7:0]          tx_mem [256];
  logic                md_q;
  logic [6:0]          axis_q;
  logic [15:0]         pre_q;
  logic [15:0]         ms_q;
  logic                pend_q;
  logic                send_pend_q;
  logic                err_rep_q;
  logic                nak_q;
  logic [7:0]          err_ax_q;
  logic [7:0]          err_cm_q;
  logic [7:0]          sum_q;
  logic [7:0]          n_q;
  logic [8:0]          cnt_q;
  logic [8:0]          idx_q;
  logic [3:0]          retries_q;
  logic [4:0]          stat_q;
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;

  logic                ev_rx;
  logic [7:0]          rxd;
  logic                byte_done;
  logic                want;
  logic                fire;
  logic [7:0]          out_byte;
  logic                t1_exp;
  logic                t2_exp;
  logic                t6_ok;
  logic [8:0]          tx_len;
  logic [7:0]          tx_cur;
  logic                rx_last;
  logic                tx_last;
  logic                bad_cnt;
  logic                init_hit;
  logic                fail;
  logic                give_up;
  logic                ack_in;
  logic                yield;
  logic                sw_send;
  logic                wr_en;
  logic [4:0]          st_set;
  logic [4:0]          st_clr;
  logic [31:0]         rd_d;
  logic                err_d;
  logic                rx_mode;
  logic                tx_mode;

  function automatic logic [7:0] recog(input logic [6:0] a);
    return shp_pkg::RECOG_MARK | {1'b0, a};
  endfunction

  function automatic shp_pkg::shp_prm_t fix_prm(
    input shp_pkg::shp_prm_t p,
    input logic              md
  );
    shp_pkg::shp_prm_t r;
    r = p;
    if (r.t1 == 8'h00) r.t1 = 8'h01;
    if (r.t2 == 8'h00) r.t2 = 8'h01;
    if (r.retry_limit == 4'h0) r.retry_limit = 4'h1;
    if (r.retry_limit > shp_pkg::RETRY_MAX) r.retry_limit = shp_pkg::RETRY_MAX;
    if (md && r.t6 < shp_pkg::MD_MIN_DELAY) r.t6 = shp_pkg::MD_MIN_DELAY;
    return r;
  endfunction

  // Error-only reply: count 1, axis, command/mode, code, checksum
  function automatic logic [7:0] err_byte(
    input logic [8:0] i,
    input logic [7:0] ax,
    input logic [7:0] cm
  );
    logic [7:0] s;
    s = shp_pkg::ERR_REPLY_COUNT + ax + cm + shp_pkg::ERR_CODE_COUNT;
    case (i)
      9'h000:  return shp_pkg::ERR_REPLY_COUNT;
      9'h001:  return ax;
      9'h002:  return cm;
      9'h003:  return shp_pkg::ERR_CODE_COUNT;
      default: return 8'h00 - s; // RULE10
    endcase
  endfunction

  // Commands 7 and 9 vary in length and are left to software
  function automatic logic count_bad(
    input logic [7:0] cm,
    input logic [7:0] n
  );
    case (cm[7:4]) // RULE20
      shp_pkg::CMD_ID,
      shp_pkg::CMD_STATUS: return n != 8'h00;
      shp_pkg::CMD_INIT:   return (cm[3:0] == shp_pkg::MODE_SET_P2P ||
                                   cm[3:0] == shp_pkg::MODE_SET_MD) &&
                                  n != shp_pkg::INIT_COUNT;
      default:             return 1'b0;
    endcase
  endfunction

  assign prm       = prm_q[md_q];
  // Receive strobe is issued by the bit engine at the stop bit
  assign ev_rx     = rx_byte.vld; // RULE18
  assign rxd       = rx_byte.data;
  assign byte_done = tx_end && pend_q; // RULE18
  assign t1_exp    = ms_q > 16'(prm.t1) * shp_pkg::STEPS_PER_TENTH;
  assign t2_exp    = ms_q > 16'(prm.t2) * shp_pkg::STEPS_PER_TENTH;
  assign t6_ok     = ms_q >= {8'h00, prm.t6}; // RULE14
  assign tx_len    = err_rep_q ? shp_pkg::ERR_REPLY_LEN
                   : 9'(tx_mem[0]) + shp_pkg::BLOCK_OVERHEAD;
  assign tx_cur    = err_rep_q ? err_byte(idx_q, err_ax_q, err_cm_q)
                   : tx_mem[idx_q[7:0]];
  assign rx_last   = ev_rx && state_q == shp_pkg::S_RX_BLK &&
                     cnt_q + 9'h001 == 9'(n_q) + shp_pkg::BLOCK_OVERHEAD;
  assign tx_last   = idx_q + 9'h001 == tx_len;
  assign bad_cnt   = count_bad(rx_mem[2], n_q); // RULE19
  assign init_hit  = !bad_cnt && rx_mem[2][7:4] == shp_pkg::CMD_INIT &&
                     (rx_mem[2][3:0] == shp_pkg::MODE_SET_P2P ||
                      rx_mem[2][3:0] == shp_pkg::MODE_SET_MD);
  assign ack_in    = state_q == shp_pkg::S_WAIT_ACK && ev_rx &&
                     rxd == shp_pkg::ACK_CODE; // RULE4
  assign yield     = state_q == shp_pkg::S_WAIT_EOT && ev_rx &&
                     rxd == shp_pkg::ENQ_CODE && !prm.ms; // RULE3 RULE16
  assign fail      = (state_q == shp_pkg::S_WAIT_EOT && !ev_rx && t2_exp) ||
                     (state_q == shp_pkg::S_WAIT_EOT_ID && !ev_rx &&
                      t1_exp) ||
                     (state_q == shp_pkg::S_WAIT_ACK &&
                      (ev_rx ? rxd != shp_pkg::ACK_CODE : t2_exp)); // RULE5
  assign give_up   = fail && retries_q >= prm.retry_limit; // RULE15
  assign rx_mode   = state_q == shp_pkg::S_WAIT_FIRST ||
                     state_q == shp_pkg::S_RX_BLK;
  assign tx_mode   = state_q == shp_pkg::S_TX_BLK ||
                     state_q == shp_pkg::S_WAIT_ACK;
  assign fire      = want && !pend_q;
  assign tx_byte   = tx_q;

  always_comb begin
    want     = 1'b0;
    out_byte = 8'h00;
    unique case (state_q)
      shp_pkg::S_EOT_TX: begin
        want     = t6_ok; // RULE14
        out_byte = shp_pkg::EOT_CODE; // RULE25
      end
      shp_pkg::S_REPLY: begin
        want     = t6_ok; // RULE14
        out_byte = nak_q ? shp_pkg::NAK_CODE : shp_pkg::ACK_CODE; // RULE7
      end
      shp_pkg::S_ENQ_TX: begin
        want     = 1'b1;
        out_byte = shp_pkg::ENQ_CODE; // RULE25
      end
      shp_pkg::S_EOT_ID_TX,
      shp_pkg::S_ENQ_ID_TX: begin
        want     = 1'b1;
        out_byte = recog(axis_q); // RULE26
      end
      shp_pkg::S_TX_BLK: begin
        // Only the first byte waits; the rest go out back to back
        want     = idx_q != 9'h000 || t6_ok; // RULE4 RULE14
        out_byte = tx_cur;
      end
      default: begin
        want     = 1'b0;
        out_byte = 8'h00;
      end
    endcase
  end

  // Step timer restarts at every character boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 16'h0000;
      ms_q  <= 16'h0000;
    end else if (ev_rx || byte_done || state_q == shp_pkg::S_IDLE) begin
      pre_q <= 16'h0000;
      ms_q  <= 16'h0000;
    end else if (pre_q == 16'(STEP_CYC - 1)) begin
      pre_q <= 16'h0000;
      if (ms_q != 16'hffff) ms_q <= ms_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q   <= '0;
      pend_q <= 1'b0;
    end else begin
      if (fire) begin
        tx_q   <= '{vld: 1'b1, data: out_byte};
        pend_q <= 1'b1;
      end else if (tx_q.vld && tx_ready) begin
        tx_q.vld <= 1'b0;
      end
      if (byte_done) pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk) begin
    if (ev_rx && (state_q == shp_pkg::S_WAIT_FIRST || rx_mode))
      rx_mem[cnt_q[7:0]] <= rxd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= shp_pkg::S_IDLE;
      send_pend_q <= 1'b0;
      err_rep_q   <= 1'b0;
      nak_q       <= 1'b0;
      err_ax_q    <= 8'h00;
      err_cm_q    <= 8'h00;
      sum_q       <= 8'h00;
      n_q         <= 8'h00;
      cnt_q       <= 9'h000;
      idx_q       <= 9'h000;
      retries_q   <= 4'h0;
    end else begin
      unique case (state_q)
        shp_pkg::S_IDLE: begin
          retries_q <= 4'h0;
          if (ev_rx && rxd == shp_pkg::ENQ_CODE)
            state_q <= md_q ? shp_pkg::S_ENQ_ID : shp_pkg::S_EOT_TX;
          else if (send_pend_q)
            state_q <= shp_pkg::S_ENQ_TX;
        end
        shp_pkg::S_ENQ_ID: begin
          if (ev_rx)
            state_q <= rxd == recog(axis_q) ? shp_pkg::S_EOT_TX
                       : shp_pkg::S_IDLE; // RULE28
          else if (t1_exp)
            state_q <= shp_pkg::S_IDLE;
        end
        shp_pkg::S_EOT_TX: begin
          cnt_q <= 9'h000;
          if (byte_done)
            state_q <= md_q ? shp_pkg::S_EOT_ID_TX
                       : shp_pkg::S_WAIT_FIRST; // RULE1
        end
        shp_pkg::S_EOT_ID_TX: begin
          if (byte_done) state_q <= shp_pkg::S_WAIT_FIRST; // RULE1
        end
        shp_pkg::S_WAIT_FIRST: begin
          if (ev_rx) begin
            n_q     <= rxd; // RULE6
            sum_q   <= rxd;
            cnt_q   <= 9'h001;
            state_q <= shp_pkg::S_RX_BLK;
          end else if (t2_exp) begin
            nak_q   <= 1'b1; // RULE13
            state_q <= shp_pkg::S_REPLY;
          end
        end
        shp_pkg::S_RX_BLK: begin
          if (ev_rx) begin
            sum_q <= sum_q + rxd; // RULE27
            cnt_q <= cnt_q + 9'h001;
          end
          if (rx_last) begin
            nak_q   <= sum_q + rxd != 8'h00 ||
                       n_q > shp_pkg::MAX_COUNT; // RULE7 RULE8
            state_q <= shp_pkg::S_REPLY;
          end else if (!ev_rx && t1_exp) begin
            nak_q   <= 1'b1; // RULE11
            state_q <= shp_pkg::S_REPLY;
          end
        end
        shp_pkg::S_REPLY: begin
          if (byte_done) begin
            if (!nak_q && bad_cnt) begin
              err_rep_q   <= 1'b1; // RULE19
              send_pend_q <= 1'b1;
              err_ax_q    <= rx_mem[1]; // RULE9
              err_cm_q    <= rx_mem[2];
            end
            nak_q   <= 1'b0;
            state_q <= shp_pkg::S_IDLE;
          end
        end
        shp_pkg::S_ENQ_TX: begin
          idx_q <= 9'h000;
          if (byte_done)
            state_q <= md_q ? shp_pkg::S_ENQ_ID_TX : shp_pkg::S_WAIT_EOT;
        end
        shp_pkg::S_ENQ_ID_TX: begin
          if (byte_done) state_q <= shp_pkg::S_WAIT_EOT;
        end
        shp_pkg::S_WAIT_EOT: begin
          if (yield)
            state_q <= md_q ? shp_pkg::S_ENQ_ID : shp_pkg::S_EOT_TX;
          else if (ev_rx && rxd == shp_pkg::EOT_CODE)
            state_q <= md_q ? shp_pkg::S_WAIT_EOT_ID
                       : shp_pkg::S_TX_BLK; // RULE2
        end
        shp_pkg::S_WAIT_EOT_ID: begin
          if (ev_rx && rxd[7]) state_q <= shp_pkg::S_TX_BLK; // RULE26
        end
        shp_pkg::S_TX_BLK: begin
          if (byte_done) begin
            idx_q <= idx_q + 9'h001;
            if (tx_last) state_q <= shp_pkg::S_WAIT_ACK; // RULE4
          end
        end
        shp_pkg::S_WAIT_ACK: begin
          if (ack_in) begin
            send_pend_q <= 1'b0;
            err_rep_q   <= 1'b0;
            state_q     <= shp_pkg::S_IDLE;
          end
        end
      endcase
      if (fail) begin
        if (give_up) begin
          send_pend_q <= 1'b0; // RULE15
          err_rep_q   <= 1'b0;
          state_q     <= shp_pkg::S_IDLE;
        end else begin
          retries_q <= retries_q + 4'h1;
          state_q   <= shp_pkg::S_ENQ_TX; // RULE5 RULE12
        end
      end
      if (sw_send) send_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prm_q[0] <= shp_pkg::P2P_DEFAULT;
      prm_q[1] <= shp_pkg::MD_DEFAULT;
    end else if (state_q == shp_pkg::S_REPLY && byte_done && !nak_q &&
                 init_hit) begin
      prm_q[rx_mem[2][3:0] == shp_pkg::MODE_SET_MD] <= fix_prm(
        '{ms: rx_mem[7][0], retry_limit: rx_mem[6][3:0], t6: rx_mem[5],
          t2: rx_mem[4], t1: rx_mem[3]},
        rx_mem[2][3:0] == shp_pkg::MODE_SET_MD); // RULE21
    end else if (wr_en && paddr == shp_pkg::PRM_OFS) begin
      prm_q[md_q] <= fix_prm(pwdata[28:0], md_q);
    end
  end

  // Status flags: a hardware set in the clearing cycle wins
  assign st_set[shp_pkg::ST_RX_OK]    = state_q == shp_pkg::S_REPLY &&
                                        byte_done && !nak_q;
  assign st_set[shp_pkg::ST_TX_OK]    = ack_in;
  assign st_set[shp_pkg::ST_TX_ERR]   = give_up;
  assign st_set[shp_pkg::ST_CNT_ERR]  = st_set[shp_pkg::ST_RX_OK] && bad_cnt;
  assign st_set[shp_pkg::ST_NAK_SENT] = state_q == shp_pkg::S_REPLY &&
                                        byte_done && nak_q;
  assign st_clr = wr_en && paddr == shp_pkg::STAT_OFS ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_q <= 5'h00;
    else          stat_q <= (stat_q & ~st_clr) | st_set;
  end

  assign wr_en   = psel && penable && pready_q && pwrite;
  assign sw_send = wr_en && paddr == shp_pkg::CTRL_OFS &&
                   pwdata[shp_pkg::CTRL_SEND_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_q   <= 1'b0;
      axis_q <= shp_pkg::AXIS_RESET;
    end else if (wr_en && paddr == shp_pkg::CTRL_OFS) begin
      md_q   <= pwdata[shp_pkg::CTRL_MD_BIT];
      axis_q <= pwdata[shp_pkg::CTRL_AXIS_LSB +: 7];
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en && paddr[11:10] == shp_pkg::TX_REGION)
      tx_mem[paddr[9:2]] <= pwdata[7:0];
  end

  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr[11:10])
      shp_pkg::REG_REGION: begin
        if (paddr == shp_pkg::CTRL_OFS)
          rd_d = {17'h00000, axis_q, 7'h00, md_q};
        else if (paddr == shp_pkg::PRM_OFS)
          rd_d = {3'h0, prm};
        else if (paddr == shp_pkg::STAT_OFS)
          rd_d = {8'h00, n_q, 5'h00, tx_mode, rx_mode,
                  state_q != shp_pkg::S_IDLE, 3'h0, stat_q};
        else
          err_d = 1'b1;
      end
      shp_pkg::RX_REGION: begin
        rd_d  = {24'h000000, rx_mem[paddr[9:2]]};
        err_d = pwrite;
      end
      shp_pkg::TX_REGION: rd_d = {24'h000000, tx_mem[paddr[9:2]]};
      default:            err_d = 1'b1;
    endcase
  end

  // One wait-free access cycle; data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && err_d;
      if (psel && !penable) prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence reply_sent_s;
    state_q == shp_pkg::S_REPLY && byte_done;
  endsequence

  eot_to_rx_a: assert property ( // RULE1
    state_q == shp_pkg::S_EOT_TX && byte_done && !md_q && !fail
    |=> state_q == shp_pkg::S_WAIT_FIRST && rx_mode)
    else $error("EOT sent but reception mode not entered");
  tx_entry_a: assert property ( // RULE2
    state_q == shp_pkg::S_TX_BLK && $past(state_q) != shp_pkg::S_TX_BLK
    |-> $past(ev_rx))
    else $error("transmission mode entered without a received byte");
  slave_yield_a: assert property ( // RULE3
    yield && !md_q |=> state_q == shp_pkg::S_EOT_TX)
    else $error("slave did not yield to incoming ENQ");
  ack_wait_a: assert property ( // RULE4
    state_q == shp_pkg::S_TX_BLK && byte_done && tx_last
    |=> state_q == shp_pkg::S_WAIT_ACK)
    else $error("block end did not lead to ACK wait");
  nak_retry_a: assert property ( // RULE5
    state_q == shp_pkg::S_WAIT_ACK && ev_rx && rxd != shp_pkg::ACK_CODE &&
    retries_q < prm.retry_limit |=> state_q == shp_pkg::S_ENQ_TX ##1 tx_q.vld &&
    tx_q.data == shp_pkg::ENQ_CODE)
    else $error("non-ACK answer did not restart from ENQ");
  sum_ack_a: assert property ( // RULE7
    rx_last && 8'(sum_q + rxd) == 8'h00 && n_q <= shp_pkg::MAX_COUNT
    |=> state_q == shp_pkg::S_REPLY && !nak_q)
    else $error("zero-sum block not acknowledged");
  first_tmo_a: assert property ( // RULE13
    state_q == shp_pkg::S_WAIT_FIRST && t2_exp && !ev_rx
    |=> state_q == shp_pkg::S_REPLY && nak_q)
    else $error("missing first byte did not give NAK");
  resp_delay_a: assert property ( // RULE14
    fire && (state_q == shp_pkg::S_REPLY || state_q == shp_pkg::S_EOT_TX)
    |-> ms_q >= {8'h00, prm.t6})
    else $error("response sent before response delay");
  retry_err_a: assert property ( // RULE15
    give_up |=> state_q == shp_pkg::S_IDLE && stat_q[shp_pkg::ST_TX_ERR])
    else $error("retry limit exceeded without error flag");
  cnt_reply_a: assert property ( // RULE19
    reply_sent_s and (!nak_q && bad_cnt)
    |=> err_rep_q && send_pend_q)
    else $error("count mismatch did not queue error reply");

endmodule

// ### tb/shp_host.sv
`timescale 1ns/1ns
module shp_host (
  input  logic               pclk,
  input  logic               presetn,
  input  shp_pkg::shp_byte_t tx_byte,
  output logic               tx_ready,
  output logic               tx_end,
  output shp_pkg::shp_byte_t rx_byte,
  output logic [7:0]         got_q,
  output logic [7:0]         n_got_q
);
  logic [1:0] cnt_q;
  logic       busy_q;
  initial rx_byte = '{vld: 1'b0, data: 8'h00};
  // One character on the wire at a time, as a real UART
  assign tx_ready = tx_byte.vld & ~busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q  <= 1'b0;
      cnt_q   <= 2'h0;
      tx_end  <= 1'b0;
      got_q   <= 8'h00;
      n_got_q <= 8'h00;
    end else begin
      tx_end <= busy_q && cnt_q == 2'h0;
      if (tx_ready) begin
        busy_q  <= 1'b1;
        cnt_q   <= 2'h3;
        got_q   <= tx_byte.data;
        n_got_q <= n_got_q + 8'h01;
      end else if (busy_q) begin
        cnt_q  <= cnt_q - 2'h1;
        busy_q <= cnt_q != 2'h0;
      end
    end
  end
  // Idle data is inverted so a stale byte is never mistaken for a new one
  task automatic put(input logic [7:0] b);
    // Counted from the offer, so the gap after the stop bit stays >= 2 ms
    repeat (25) @(posedge pclk);
    rx_byte <= '{vld: 1'b1, data: b};
    @(posedge pclk);
    rx_byte <= '{vld: 1'b0, data: ~b};
  endtask
endmodule

// ### tb/shp_link_test.sv
`timescale 1ns/1ns
module shp_link_test;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic        r;
  } shp_row_t;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, tx_ready, tx_end, er;
  shp_pkg::shp_byte_t rx_byte, tx_byte;
  logic [7:0]         got, n_got;
  int                 k = 0;
  int                 n_errors = 0;
  int                 num_checks = 0;
  logic [7:0]         blk [4] = '{8'h00, 8'h01, 8'h01, 8'hfe};
  logic [7:0]         ini [9] = '{8'h05, 8'h01, 8'h18, 8'h03, 8'h04,
                                  8'h02, 8'h02, 8'h01, 8'hd6};
  logic [7:0]         ebl [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'hfd};
  logic [7:0]         erp [5] = '{8'h01, 8'h01, 8'h01, 8'ha0, 8'h5d};
  // Writes read back the clamped value
  shp_row_t           rows [7] = '{
    '{1'b0, 12'h000, 32'h0, 32'h0000_0100, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h0100_0505, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h004, 32'h0, 32'h0100_0101, 1'b0},
    '{1'b1, 12'h004, 32'h0900_0505, 32'h0800_0505, 1'b0},
    '{1'b1, 12'h004, 32'h0100_0505, 32'h0100_0505, 1'b0}};
  shp_link #(.STEP_CYC(10)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_byte, .tx_ready, .tx_end, .tx_byte);
  shp_host host_u (
    .pclk, .presetn, .tx_byte, .tx_ready, .tx_end, .rx_byte,
    .got_q(got), .n_got_q(n_got));
  initial forever #20 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic get(input logic [7:0] e);
    for (int i = 0; i < 5000 && n_got == k; i++) @(posedge pclk);
    // A byte that never came is a mismatch, not a stale match
    chk({23'h0, n_got == k, got}, {24'h0, e});
    k = n_got;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
      chk({31'h0, er}, {31'h0, rows[i].r});
    end
    for (int r = 0; r < 2; r++) begin
      host_u.put(shp_pkg::ENQ_CODE);
      get(shp_pkg::EOT_CODE);
      // Second pass spoils only the checksum, so the sum check answers
      for (int i = 0; i < 4; i++) host_u.put(r && i == 3 ? ~blk[i] : blk[i]);
      get(r ? shp_pkg::NAK_CODE : shp_pkg::ACK_CODE);
    end
    for (int i = 0; i < 4; i++)
      apb(1'b1, 12'h800 + 12'(4 * i), {24'h0, blk[i]});
    apb(1'b1, shp_pkg::CTRL_OFS, 32'h0000_0102);
    // First attempt is refused so the retry path runs
    for (int r = 0; r < 2; r++) begin
      get(shp_pkg::ENQ_CODE);
      host_u.put(shp_pkg::EOT_CODE);
      for (int i = 0; i < 4; i++) get(blk[i]);
      host_u.put(r ? shp_pkg::ACK_CODE : shp_pkg::NAK_CODE);
    end
    apb(1'b0, shp_pkg::STAT_OFS, 32'h0);
    chk({31'h0, rd[shp_pkg::ST_TX_OK]}, 32'h1);
    // Host ENQ while the device waits for EOT: slave yields, sends later
    apb(1'b1, shp_pkg::CTRL_OFS, 32'h0000_0102);
    get(shp_pkg::ENQ_CODE);
    host_u.put(shp_pkg::ENQ_CODE);
    get(shp_pkg::EOT_CODE);
    for (int i = 0; i < 4; i++) host_u.put(blk[i]);
    get(shp_pkg::ACK_CODE);
    get(shp_pkg::ENQ_CODE);
    host_u.put(shp_pkg::EOT_CODE);
    for (int i = 0; i < 4; i++) get(blk[i]);
    host_u.put(shp_pkg::ACK_CODE);
    // Wrong count for the command: ACK, then an error-code-only reply
    host_u.put(shp_pkg::ENQ_CODE);
    get(shp_pkg::EOT_CODE);
    foreach (ebl[i]) host_u.put(ebl[i]);
    get(shp_pkg::ACK_CODE);
    get(shp_pkg::ENQ_CODE);
    host_u.put(shp_pkg::EOT_CODE);
    foreach (erp[i]) get(erp[i]);
    host_u.put(shp_pkg::ACK_CODE);
    // Link-side rewrite of set 0 lands once its ACK has gone out
    host_u.put(shp_pkg::ENQ_CODE);
    get(shp_pkg::EOT_CODE);
    foreach (ini[i]) host_u.put(ini[i]);
    get(shp_pkg::ACK_CODE);
    repeat (10) @(posedge pclk);
    apb(1'b0, shp_pkg::PRM_OFS, 32'h0);
    chk(rd, 32'h1202_0403);
    final_report;
  end
endmodule
